// *** verif/wdr_proc_model.sv ***
// Processor model that toggles the watchdog strobe
`timescale 1ns/100ps
`default_nettype none

module wdr_proc_model (
  input  wire logic        aclk,        // Clock
  input  wire logic        reset_out_n, // Reset from the device
  input  wire logic [15:0] interval,    // Cycles between toggles, zero stops
  output var  logic        strobe       // Watchdog strobe
);
  logic [15:0] cnt      = 16'h0000;
  logic        strobe_q = 1'b0;

  // Strobe level held in one register
  assign strobe = strobe_q;

  // --------------------------------------------------------------
  // Strobe toggling
  // --------------------------------------------------------------
  // Held in reset, the processor runs no code
  always @(posedge aclk) begin
    if (!reset_out_n || interval == 16'h0000) begin
      cnt <= 16'h0000;
    end else if (cnt >= interval - 16'h0001) begin
      cnt    <= 16'h0000;
      strobe_q <= ~strobe_q; // Interval as commanded by the bench
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule // wdr_proc_model

`default_nettype wire

// *** verif/wdr_watchdog_chk.sv ***
// Assertion checker for the windowed watchdog reset timer
`timescale 1ns/100ps
`default_nettype none
`include "wdr_consts.svh"

module wdr_watchdog_chk
#(
  parameter logic [`WDR_CW-1:0] FIXED_RESET_CYCLES = 40'h00_0000_0028
) (
  input wire logic                  aclk,          // Clock
  input wire logic                  aresetn,       // Reset, active low
  input wire wdr_pkg::wdr_pins_type pins,          // Device pins
  input wire logic                  reset_out_n,   // Processor reset
  input wire logic                  s_axi_awvalid, // Write address valid
  input wire logic                  s_axi_awready, // Write address ready
  input wire logic                  s_axi_wvalid,  // Write data valid
  input wire logic                  s_axi_wready,  // Write data ready
  input wire logic [1:0]            s_axi_bresp,   // Write response
  input wire logic                  s_axi_bvalid,  // Write response valid
  input wire logic                  s_axi_bready,  // Write response ready
  input wire logic                  s_axi_arvalid, // Read address valid
  input wire logic                  s_axi_arready, // Read address ready
  input wire logic [31:0]           s_axi_rdata,   // Read data
  input wire logic                  s_axi_rvalid,  // Read valid
  input wire logic                  s_axi_rready   // Read ready
);
  import wdr_pkg::*;
  logic [`WDR_CW-1:0] low_cnt;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Length of the current low phase of the reset output
  always_ff @(posedge aclk) begin
    low_cnt <= (!aresetn || reset_out_n) ? `WDR_ZERO : low_cnt + `WDR_ONE;
  end

  // --------------------------------------------------------------
  // Sequences and properties
  // --------------------------------------------------------------
  sequence s_wd_off;
    ((!pins.watchdog_off_n || pins.load_below_low ||
      (pins.window_ratio_sel0 && !pins.window_ratio_sel1)) &&
     pins.regulator_ok && !pins.reset_cap_gnd) [*6];
  endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  property p_gnd_low;
    pins.reset_cap_gnd [*6] |-> !reset_out_n;
  endproperty
  property p_fixed_hold;
    $rose(reset_out_n) && pins.reset_cap_fixed |-> low_cnt >= FIXED_RESET_CYCLES;
  endproperty
  property p_reg_low;
    !pins.regulator_ok [*6] |-> !reset_out_n;
  endproperty
  property p_wd_off;
    s_wd_off |-> !$fell(reset_out_n);
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_time;
    s_wr_both |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  property p_r_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_gnd_low: assert property (p_gnd_low)
    else $error("reset output high with reset cap pin grounded");
  a_fixed_hold: assert property (p_fixed_hold)
    else $error("reset output released before fixed hold period");
  a_reg_low: assert property (p_reg_low)
    else $error("reset output high with regulator below threshold");
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog reset while watchdog disabled");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped or changed before taken");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped or changed before taken");
  a_b_time: assert property (p_b_time)
    else $error("write response late");
  a_r_time: assert property (p_r_time)
    else $error("read response late");
  a_ar_block: assert property (p_ar_block)
    else $error("read address accepted while read pending");
endmodule // wdr_watchdog_chk

bind wdr_watchdog wdr_watchdog_chk #(.FIXED_RESET_CYCLES(FIXED_RESET_CYCLES)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .pins(pins), .reset_out_n(reset_out_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

`default_nettype wire

// *** verif/windowed_watchdog_reset_timer_tb_top.sv ***
// Testbench for the windowed watchdog reset timer
`timescale 1ns/100ps
`default_nettype none

module windowed_watchdog_reset_timer_tb_top;
  import wdr_pkg::*;
  typedef struct packed {
    logic [1:0] sel; logic off_n; logic low; logic high; logic [15:0] ivl; logic [1:0] fault;
  } wdr_row_type;
  logic aclk = 1'b0, aresetn = 1'b0, reset_out_n, strobe;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready, saw;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] ivl = 16'h0064;
  wdr_pins_type cfg = 10'h0cb, pins_w;
  int err_count = 0, comparisons = 0, cyc = 0, n;
  wdr_row_type rows [13] = '{
    '{2'h0, 1'h1, 1'h0, 1'h1, 16'h0064, 2'h0}, '{2'h0, 1'h1, 1'h0, 1'h1, 16'h0014, 2'h1},
    '{2'h1, 1'h1, 1'h0, 1'h1, 16'h0028, 2'h0}, '{2'h1, 1'h1, 1'h0, 1'h1, 16'h000a, 2'h1},
    '{2'h3, 1'h1, 1'h0, 1'h1, 16'h000c, 2'h0}, '{2'h3, 1'h1, 1'h0, 1'h1, 16'h0004, 2'h1},
    '{2'h0, 1'h1, 1'h0, 1'h1, 16'h0000, 2'h2}, '{2'h2, 1'h1, 1'h0, 1'h1, 16'h0004, 2'h0},
    '{2'h2, 1'h1, 1'h0, 1'h1, 16'h0000, 2'h0}, '{2'h0, 1'h0, 1'h0, 1'h1, 16'h0000, 2'h0},
    '{2'h0, 1'h1, 1'h1, 1'h1, 16'h0000, 2'h0}, '{2'h0, 1'h1, 1'h0, 1'h0, 16'h0000, 2'h0},
    '{2'h0, 1'h1, 1'h0, 1'h1, 16'h0000, 2'h2}};

  always #25 aclk = ~aclk;
  // Strobe from the processor model merged into the pin bundle
  always_comb begin
    pins_w = cfg;
    pins_w.watchdog_strobe_in = strobe;
  end

  wdr_watchdog #(.FIXED_RESET_CYCLES(40'h00_0000_0028),
                 .FIXED_SLOW_CYCLES(40'h00_0000_0190)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .pins(pins_w), .reset_out_n(reset_out_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  wdr_proc_model proc_u (.aclk(aclk), .reset_out_n(reset_out_n), .interval(ivl), .strobe(strobe));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin r = s_axi_bresp; done = 1'b1; s_axi_bready <= 1'b0; end
    end
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata; r = s_axi_rresp; done = 1'b1; s_axi_rready <= 1'b0;
      end
    end
  endtask
  // Cycles for which the reset output keeps the given level
  task automatic span(input logic lvl, output int c);
    c = 0;
    while (reset_out_n === lvl) begin @(posedge aclk); c++; end
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin err_count++; complete_run(); end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    check("reset_in_reset", 32'(reset_out_n), 32'h0000_0000);
    aresetn <= 1'b1;
    span(1'b0, n);
    check("powerup_hold", 32'(n >= 40 && n <= 48), 32'h0000_0001);
    axi_rd(5'h00, rd, rsp); check("rst_cap", rd, 32'h0000_0000);
    axi_rd(5'h04, rd, rsp); check("wd_cap", rd, 32'h0000_0000);
    axi_rd(5'h08, rd, rsp); check("status", rd, 32'h0000_0007);
    axi_rd(5'h14, rd, rsp); check("unmapped_rd", rd, 32'h0000_0000);
    check("unmapped_rresp", 32'(rsp), 32'h0000_0002);
    axi_wr(5'h14, 32'h0000_0001, rsp); check("unmapped_wr", 32'(rsp), 32'h0000_0002);
    axi_rd(5'h04, rd, rsp); check("wd_cap_kept", rd, 32'h0000_0000);
    foreach (rows[i]) begin
      @(posedge aclk);
      {cfg.window_ratio_sel0, cfg.window_ratio_sel1} <= rows[i].sel;
      cfg.watchdog_off_n <= rows[i].off_n; cfg.load_below_low <= rows[i].low;
      cfg.load_above_high <= rows[i].high; ivl <= 16'h0064;
      span(1'b0, n);
      repeat (300) @(posedge aclk);
      axi_wr(5'h0c, 32'h0000_0003, rsp);
      ivl <= rows[i].ivl; saw = 1'b0;
      repeat (800) begin @(posedge aclk); if (!reset_out_n) saw = 1'b1; end
      ivl <= 16'h0064;
      axi_rd(5'h0c, rd, rsp);
      check("fault", rd, {30'h0, rows[i].fault});
      check("saw_reset", 32'(saw), 32'(rows[i].fault != 2'h0));
    end
    // Capacitor-derived hold of 73 and slow limit of 31000 cycles
    axi_wr(5'h00, 32'h0000_0003, rsp); axi_wr(5'h04, 32'h0000_000a, rsp);
    // Strobes stop with the switch, so no fast fault cuts into the measured spans
    ivl <= 16'h0000; cfg.reset_cap_fixed <= 1'b0; cfg.wd_cap_fixed <= 1'b0;
    span(1'b0, n); repeat (100) @(posedge aclk);
    span(1'b1, n); span(1'b0, n);
    check("cap_hold", 32'(n >= 73 && n <= 75), 32'h0000_0001);
    span(1'b1, n);
    check("cap_slow", 32'(n >= 31000 && n <= 31003), 32'h0000_0001);
    span(1'b0, n);
    cfg.reset_cap_fixed <= 1'b1; cfg.wd_cap_fixed <= 1'b1; ivl <= 16'h0064;
    // Grounded cap pin, then regulator drop, each followed by a fixed hold
    cfg.reset_cap_gnd <= 1'b1; repeat (20) @(posedge aclk);
    check("gnd_low", 32'(reset_out_n), 32'h0000_0000);
    cfg.reset_cap_gnd <= 1'b0; span(1'b0, n);
    check("gnd_hold", 32'(n >= 40), 32'h0000_0001);
    cfg.regulator_ok <= 1'b0; repeat (20) @(posedge aclk);
    check("reg_low", 32'(reset_out_n), 32'h0000_0000);
    cfg.regulator_ok <= 1'b1; span(1'b0, n);
    check("reg_hold", 32'(n >= 40), 32'h0000_0001);
    complete_run();
  end
endmodule // windowed_watchdog_reset_timer_tb_top

`default_nettype wire

// *** verilog/wdr_consts.svh ***
// Constants of the windowed watchdog reset timer
//
// Behaviour
// - Reset cap pin grounded holds reset low
// - Reset cap pin tied high: fixed hold period
// - Hold period equals capacitance times 1.218e6
// - Slow limit equals capacitance times 155e6
// - Watchdog cap pin tied high: fixed slow limit
// - Fast limit is slow limit over ratio
// - Select 00=8, 01=16, 10=off, 11=64
// - Edges closer than fast limit cause reset
// - Interval beyond slow limit causes reset
// - Strobe edges ignored while reset is low
// - Interval timer starts at reset release
// - Interval timer cleared when reset asserts
// - Ratio select 10 disables the watchdog
// - Disable input low stops watchdog timing
// - Low load current disables the watchdog
// - Re-enable only above upper current threshold
// - Resume immediately once disables are gone
// - Voltage recovery keeps reset for hold period
`ifndef WDR_CONSTS_SVH
`define WDR_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define WDR_CLK_HZ          20000000
`define WDR_CLK_MHZ         20
`define WDR_RST_K_MILLI     1218
`define WDR_RST_K_DIV       1000
`define WDR_WD_K            155
`define WDR_FIXED_RESET_MS  200
`define WDR_FIXED_SLOW_MS   280
`define WDR_MS_PER_S        1000
`define WDR_FIXED_RESET_CYC (64'd`WDR_FIXED_RESET_MS * 64'd`WDR_CLK_HZ / 64'd`WDR_MS_PER_S)
`define WDR_FIXED_SLOW_CYC  (64'd`WDR_FIXED_SLOW_MS * 64'd`WDR_CLK_HZ / 64'd`WDR_MS_PER_S)
`define WDR_CW              40
`define WDR_ONE             40'h00_0000_0001
`define WDR_ZERO            40'h00_0000_0000

// ----------------------------------------------------------------
// Window ratio shifts (ratio = 2**shift)
// ----------------------------------------------------------------
`define WDR_SHIFT_R8        3
`define WDR_SHIFT_R16       4
`define WDR_SHIFT_R64       6

// ----------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------
`define WDR_ADDR_RST_CAP    4'h0
`define WDR_ADDR_WD_CAP     4'h4
`define WDR_ADDR_STATUS     4'h8
`define WDR_ADDR_FAULT      4'hc
`define WDR_ADDR_INTERVAL   5'h10
`define WDR_CAP_W           24
`define WDR_CAP_RESET       24'h00_0000
`define WDR_FAULT_FAST      0
`define WDR_FAULT_SLOW      1
`define WDR_RESP_OKAY       2'h0
`define WDR_RESP_SLVERR     2'h2
`define WDR_NPINS           10

`endif

// *** verilog/wdr_pkg.sv ***
// Types shared by the windowed watchdog reset timer
package wdr_pkg;

  // Strap, comparator and monitor pins, all from outside the clock domain
  typedef struct packed {
    logic watchdog_strobe_in;      // Strobe toggled by the processor
    logic reset_cap_gnd;           // Reset period cap pin tied to ground
    logic reset_cap_fixed;         // Reset period cap pin tied to regulator output
    logic wd_cap_fixed;            // Watchdog period cap pin tied to regulator output
    logic window_ratio_sel0;       // Ratio select bit 0
    logic window_ratio_sel1;       // Ratio select bit 1
    logic watchdog_off_n;          // Watchdog disable, active low
    logic load_below_low;          // Load current under lower threshold
    logic load_above_high;         // Load current over upper threshold
    logic regulator_ok;            // Monitored output above reset threshold
  } wdr_pins_type;

  // Sequencer states
  typedef enum logic [0:0] {
    WDR_HOLD,
    WDR_RUN
  } wdr_state_type;

  // Status word shown to software
  typedef struct packed {
    logic ratio_off;
    logic low_current_off;
    logic wd_enabled;
    logic running;
    logic reset_out_n;
  } wdr_status_type;

endpackage : wdr_pkg

// *** verilog/wdr_watchdog.sv ***
// Windowed watchdog reset timer with AXI4-Lite configuration slave
`timescale 1ns/100ps
`default_nettype none
`include "wdr_consts.svh"

module wdr_watchdog #(
  parameter logic [`WDR_CW-1:0] FIXED_RESET_CYCLES = `WDR_CW'(`WDR_FIXED_RESET_CYC),
  parameter logic [`WDR_CW-1:0] FIXED_SLOW_CYCLES  = `WDR_CW'(`WDR_FIXED_SLOW_CYC)
) (
  input  wire logic                 aclk,          // 20 MHz clock
  input  wire logic                 aresetn,       // Synchronous reset, active low
  input  wire wdr_pkg::wdr_pins_type pins,         // Asynchronous device pins
  output var  logic                 reset_out_n,   // Processor reset, active low
  input  wire logic [4:0]           s_axi_awaddr,  // Write address
  input  wire logic                 s_axi_awvalid, // Write address valid
  output var  logic                 s_axi_awready, // Write address ready
  input  wire logic [31:0]          s_axi_wdata,   // Write data
  input  wire logic [3:0]           s_axi_wstrb,   // Write byte enables
  input  wire logic                 s_axi_wvalid,  // Write data valid
  output var  logic                 s_axi_wready,  // Write data ready
  output var  logic [1:0]           s_axi_bresp,   // Write response
  output var  logic                 s_axi_bvalid,  // Write response valid
  input  wire logic                 s_axi_bready,  // Write response ready
  input  wire logic [4:0]           s_axi_araddr,  // Read address
  input  wire logic                 s_axi_arvalid, // Read address valid
  output var  logic                 s_axi_arready, // Read address ready
  output var  logic [31:0]          s_axi_rdata,   // Read data
  output var  logic [1:0]           s_axi_rresp,   // Read response
  output var  logic                 s_axi_rvalid,  // Read response valid
  input  wire logic                 s_axi_rready   // Read response ready
);
  import wdr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [`WDR_NPINS-1:0] pin_s1;
  logic [`WDR_NPINS-1:0] pin_s2;
  logic [`WDR_NPINS-1:0] pin_s3;
  logic [`WDR_NPINS-1:0] pin_q;
  wdr_pins_type          pin_f;
  wire  [`WDR_NPINS-1:0] pin_agree = ~(pin_s2 ^ pin_s3);

  // Three stages; a bit is taken once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_q  <= '0;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q  <= (pin_agree & pin_s3) | (~pin_agree & pin_q);
    end
  end

  assign pin_f = wdr_pins_type'(pin_q);

  // ----------------------------------------------------------------
  // Configuration registers and flags
  // ----------------------------------------------------------------
  logic [`WDR_CAP_W-1:0] rst_cap_pf;       // Reset period capacitance, pF
  logic [`WDR_CAP_W-1:0] wd_cap_pf;        // Watchdog period capacitance, pF
  logic [1:0]            fault_flags;      // Sticky fast and slow faults
  logic                  low_current_off;  // Hysteretic low-load disable
  logic                  strobe_prev;      // Last taken strobe level
  logic                  first_edge;       // Next edge only restarts timing
  wdr_state_type         state;
  logic [`WDR_CW-1:0]    hold_cnt;
  logic [`WDR_CW-1:0]    interval_cnt;

  // ----------------------------------------------------------------
  // Period derivation
  // ----------------------------------------------------------------
  // Capacitor ramps replaced by cycle counts
  wire [`WDR_CW-1:0] rst_cap_cyc = `WDR_CW'((64'(rst_cap_pf) * 64'd`WDR_RST_K_MILLI
                                   * 64'd`WDR_CLK_MHZ) / 64'd`WDR_RST_K_DIV);
  wire [`WDR_CW-1:0] wd_cap_cyc  = `WDR_CW'(64'(wd_cap_pf) * 64'd`WDR_WD_K
                                   * 64'd`WDR_CLK_MHZ);
  wire [`WDR_CW-1:0] hold_raw    = pin_f.reset_cap_fixed ? FIXED_RESET_CYCLES
                                   : rst_cap_cyc;
  wire [`WDR_CW-1:0] slow_raw    = pin_f.wd_cap_fixed ? FIXED_SLOW_CYCLES
                                   : wd_cap_cyc;
  wire [`WDR_CW-1:0] hold_period = (hold_raw == `WDR_ZERO) ? `WDR_ONE : hold_raw;
  wire [`WDR_CW-1:0] slow_limit  = (slow_raw == `WDR_ZERO) ? `WDR_ONE : slow_raw;
  wire [1:0]         ratio_sel   = {pin_f.window_ratio_sel0, pin_f.window_ratio_sel1};
  wire               ratio_off   = (ratio_sel == 2'h2);

  // Fast limit as the slow limit over 8, 16 or 64
  logic [`WDR_CW-1:0] fast_limit;
  always_comb begin
    case (ratio_sel)
      2'h0:    fast_limit = slow_limit >> `WDR_SHIFT_R8;
      2'h1:    fast_limit = slow_limit >> `WDR_SHIFT_R16;
      2'h3:    fast_limit = slow_limit >> `WDR_SHIFT_R64;
      default: fast_limit = `WDR_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Enable and fault decode
  // ----------------------------------------------------------------
  wire force_low   = pin_f.reset_cap_gnd | ~pin_f.regulator_ok;
  wire wd_enabled  = ~ratio_off & pin_f.watchdog_off_n
                     & ~low_current_off;
  wire strobe_edge = (pin_f.watchdog_strobe_in != strobe_prev);
  wire running     = (state == WDR_RUN);
  wire fast_fault  = running & wd_enabled & strobe_edge & ~first_edge
                     & (interval_cnt < fast_limit);
  wire slow_fault  = running & wd_enabled & (interval_cnt > slow_limit);
  wire hold_done   = (hold_cnt + `WDR_ONE) >= hold_period;

  // Sequencer next state
  wdr_state_type next_state;
  always_comb begin
    case (state)
      WDR_HOLD: next_state = (!force_low && hold_done) ? WDR_RUN : WDR_HOLD;
      WDR_RUN:  next_state = (force_low || fast_fault || slow_fault) ? WDR_HOLD : WDR_RUN;
      default:  next_state = WDR_HOLD;
    endcase
  end

  // Low-load disable with hysteresis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_current_off <= 1'b0;
    end else if (pin_f.load_below_low) begin
      low_current_off <= 1'b1;
    end else if (pin_f.load_above_high) begin
      low_current_off <= 1'b0;
    end
  end

  // Reset sequencer; starts in hold so power-up gets a full hold period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= WDR_HOLD;
      reset_out_n <= 1'b0;
    end else begin
      state       <= next_state;
      reset_out_n <= (next_state == WDR_RUN);
    end
  end

  // Hold counter, cleared while forced low and on entry to hold
  always_ff @(posedge aclk) begin
    if (!aresetn || running || force_low) begin
      hold_cnt <= `WDR_ZERO;
    end else begin
      hold_cnt <= hold_cnt + `WDR_ONE;
    end
  end

  // Interval timer: idle in hold, frozen at zero while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || next_state == WDR_HOLD || !running) begin
      interval_cnt <= `WDR_ZERO;
    end else if (!wd_enabled) begin
      interval_cnt <= `WDR_ZERO;
    end else if (strobe_edge) begin
      interval_cnt <= `WDR_ZERO;
    end else begin
      interval_cnt <= interval_cnt + `WDR_ONE;
    end
  end

  // Strobe history and first-edge marker
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_prev <= 1'b0;
      first_edge  <= 1'b1;
    end else begin
      strobe_prev <= pin_f.watchdog_strobe_in;
      first_edge  <= !running || !wd_enabled || (first_edge && !strobe_edge);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic [4:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire aw_have  = ~s_axi_awready & ~s_axi_bvalid;
  wire w_have   = ~s_axi_wready & ~s_axi_bvalid;
  wire wr_fire  = aw_have & w_have;
  wire b_done   = s_axi_bvalid & s_axi_bready;
  wire wr_rst   = wr_fire & (aw_addr == {1'b0, `WDR_ADDR_RST_CAP});
  wire wr_wd    = wr_fire & (aw_addr == {1'b0, `WDR_ADDR_WD_CAP});
  wire wr_fault = wr_fire & (aw_addr == {1'b0, `WDR_ADDR_FAULT});
  wire wr_map   = (aw_addr[1:0] == 2'h0) & (aw_addr <= `WDR_ADDR_INTERVAL);
  wire [31:0] w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] rst_merge = (32'(rst_cap_pf) & ~w_mask) | (w_data & w_mask);
  wire [31:0] wd_merge  = (32'(wd_cap_pf) & ~w_mask) | (w_data & w_mask);
  wire [1:0]  fault_clr = wr_fault ? (w_data[1:0] & w_mask[1:0]) : 2'h0;

  // Address and data taken in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WDR_RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      if (aw_take) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (w_take) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `WDR_RESP_OKAY : `WDR_RESP_SLVERR;
      end
      if (b_done) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Capacitance registers and sticky faults; a new fault beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cap_pf  <= `WDR_CAP_RESET;
      wd_cap_pf   <= `WDR_CAP_RESET;
      fault_flags <= 2'h0;
    end else begin
      if (wr_rst) begin
        rst_cap_pf <= rst_merge[`WDR_CAP_W-1:0];
      end
      if (wr_wd) begin
        wd_cap_pf <= wd_merge[`WDR_CAP_W-1:0];
      end
      fault_flags <= (fault_flags & ~fault_clr) | {slow_fault, fast_fault};
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  wdr_status_type status_word;
  assign status_word = '{ratio_off:       ratio_off,
                         low_current_off: low_current_off,
                         wd_enabled:      wd_enabled,
                         running:         running,
                         reset_out_n:     reset_out_n};

  // Read data selection by word address
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok = (s_axi_araddr[1:0] == 2'h0);
    case (s_axi_araddr)
      {1'b0, `WDR_ADDR_RST_CAP}:  rd_mux = 32'(rst_cap_pf);
      {1'b0, `WDR_ADDR_WD_CAP}:   rd_mux = 32'(wd_cap_pf);
      {1'b0, `WDR_ADDR_STATUS}:   rd_mux = 32'(status_word);
      {1'b0, `WDR_ADDR_FAULT}:    rd_mux = 32'(fault_flags);
      `WDR_ADDR_INTERVAL:         rd_mux = interval_cnt[31:0];
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // One read in flight; answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `WDR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? `WDR_RESP_OKAY : `WDR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // wdr_watchdog

`default_nettype wire
